// [hdl/fault_log_force_on_regs.sv]
`timescale 1ns/1ps
// Function
// R1: Force-on control bits 3:0, upper zero
// R2: Key register, unlocks force-on at A5
// R3: Fault events set per-channel status bits
// R4: Breaker shutdowns logged slow and fast
// R5: Undervoltage warning low, critical high nibble
// R6: Overvoltage warning low, critical high nibble
// R7: Overcurrent warnings low nibble, upper unused
// R8: Per-channel fault output on breaker shutdown
// R9: Attention output when anything logged
// R10: Forced channel enabled, never fault-shut
// R11: Locked key makes force bits ineffective
// R12: Attention active low, OR of logs
// R13: Trip log held until zero write/restart
// R14: Fault bits sticky until host clears
module fault_log_force_on_regs
	import fault_log_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       regWr,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	output logic      [7:0] regRdata,
	input  wire logic [3:0] lowVoltWarnEv,
	input  wire logic [3:0] lowVoltCritEv,
	input  wire logic [3:0] highVoltWarnEv,
	input  wire logic [3:0] highVoltCritEv,
	input  wire logic [3:0] overcurrentWarnEv,
	input  wire logic [3:0] slowTripEv,
	input  wire logic [3:0] fastTripEv,
	input  wire logic [3:0] channelRestart,
	input  wire logic [3:0] channelEnableIn,
	input  wire logic [3:0] faultShutdownReq,
	output logic      [3:0] channelForceFlag,
	output logic      [3:0] channelOn,
	output logic      [3:0] faultOut_n,
	output logic      [3:0] faultOutEn,
	output logic            alert_n,
	output logic            alertEn
);
	typedef struct packed {
		logic [7:0] key_ff;
		logic [3:0] force_ff;
		logic [7:0] rdata_ff;
	} state_t;
	state_t st_ff;
	state_t nxt_st;

	logic [7:0] uvFlags;
	logic [7:0] ovFlags;
	logic [3:0] ocFlags;
	logic [7:0] tripLog;
	logic       unlocked;
	logic [3:0] forceEff;

	logic [7:0] rdWord;
	logic [3:0] tripClr;
	logic [3:0] tripPerCh;
	logic [3:0] logAny;

	// Address decode for the write strobes; the read mux decodes regAddr itself
	logic hitTrip;
	logic hitUv;
	logic hitOv;
	logic hitOc;
	logic hitKey;
	logic hitCtl;
	assign hitTrip = (regAddr == ADDR_TRIP_LOG);
	assign hitUv   = (regAddr == ADDR_UV_FLAGS);
	assign hitOv   = (regAddr == ADDR_OV_FLAGS);
	assign hitOc   = (regAddr == ADDR_OC_FLAGS);
	assign hitKey  = (regAddr == ADDR_FORCE_KEY);
	assign hitCtl  = (regAddr == ADDR_FORCE_CTL);

	// Write strobes; any data clears a fault log, the trip log only zero
	logic clrUv;
	logic clrOv;
	logic clrOc;
	logic clrTrip;
	assign clrUv   = regWr && hitUv; // see R14
	assign clrOv   = regWr && hitOv; // see R14
	assign clrOc   = regWr && hitOc; // see R14
	assign clrTrip = regWr && hitTrip && (regWdata == 8'h00); // see R13

	// Trip bits of a channel also clear when that channel restarts
	assign tripClr = {4{clrTrip}} | channelRestart; // see R13

	// Sticky log bits, seven per channel; a set beats a clear
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			// Undervoltage warning, low nibble
			sticky_flag uvWarn (
				.ref_clk (ref_clk),
				.rst     (rst),
				.setEv   (lowVoltWarnEv[ch]),
				.clrEv   (clrUv),
				.flag    (uvFlags[WARN_LSB+ch])
			); // see R3, R5, R14

			// Undervoltage critical, high nibble
			sticky_flag uvCrit (
				.ref_clk (ref_clk),
				.rst     (rst),
				.setEv   (lowVoltCritEv[ch]),
				.clrEv   (clrUv),
				.flag    (uvFlags[CRIT_LSB+ch])
			); // see R3, R5

			// Overvoltage warning, low nibble
			sticky_flag ovWarn (
				.ref_clk (ref_clk),
				.rst     (rst),
				.setEv   (highVoltWarnEv[ch]),
				.clrEv   (clrOv),
				.flag    (ovFlags[WARN_LSB+ch])
			); // see R3, R6, R14

			// Overvoltage critical, high nibble
			sticky_flag ovCrit (
				.ref_clk (ref_clk),
				.rst     (rst),
				.setEv   (highVoltCritEv[ch]),
				.clrEv   (clrOv),
				.flag    (ovFlags[CRIT_LSB+ch])
			); // see R3, R6

			// Overcurrent warning, low nibble only
			sticky_flag ocWarn (
				.ref_clk (ref_clk),
				.rst     (rst),
				.setEv   (overcurrentWarnEv[ch]),
				.clrEv   (clrOc),
				.flag    (ocFlags[ch])
			); // see R3, R7, R14

			// Slow trip, high nibble of the trip log
			sticky_flag slowTrip (
				.ref_clk (ref_clk),
				.rst     (rst),
				.setEv   (slowTripEv[ch]),
				.clrEv   (tripClr[ch]),
				.flag    (tripLog[CRIT_LSB+ch])
			); // see R4, R13

			// Fast trip, low nibble of the trip log
			sticky_flag fastTrip (
				.ref_clk (ref_clk),
				.rst     (rst),
				.setEv   (fastTripEv[ch]),
				.clrEv   (tripClr[ch]),
				.flag    (tripLog[WARN_LSB+ch])
			); // see R4, R13

			// Breaker shutdown of this channel, either trip
			assign tripPerCh[ch] = tripLog[CRIT_LSB+ch] | tripLog[WARN_LSB+ch]; // see R8
		end
	endgenerate

	// Force bits are kept while locked and only count once unlocked
	assign unlocked = (st_ff.key_ff == UNLOCK_KEY); // see R2, R11
	assign forceEff = unlocked ? st_ff.force_ff : 4'h0; // see R11

	// Read mux; reads have no side effects
	always_comb begin
		unique case (regAddr)
			ADDR_TRIP_LOG:  rdWord = tripLog;
			ADDR_UV_FLAGS:  rdWord = uvFlags;
			ADDR_OV_FLAGS:  rdWord = ovFlags;
			ADDR_OC_FLAGS:  rdWord = {4'h0, ocFlags}; // see R7
			ADDR_FORCE_KEY: rdWord = st_ff.key_ff;
			ADDR_FORCE_CTL: rdWord = {4'h0, st_ff.force_ff}; // see R1
			default:        rdWord = 8'h00;
		endcase
	end

	// Register writes and the registered read word
	always_comb begin
		nxt_st = st_ff;
		if (regWr && hitKey) begin
			nxt_st.key_ff = regWdata; // see R2
		end
		if (regWr && hitCtl) begin
			nxt_st.force_ff = regWdata[3:0]; // see R1
		end
		nxt_st.rdata_ff = rdWord;
	end

	// Register the state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_ff.key_ff   <= RST_KEY;
			st_ff.force_ff <= RST_FORCE;
			st_ff.rdata_ff <= RST_FLAGS;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Registered read word to the port
	assign regRdata         = st_ff.rdata_ff;

	// Effective force flags, gated by the key
	assign channelForceFlag = forceEff; // see R11

	// Forced channels on and immune to fault shutdown
	assign channelOn = forceEff | (channelEnableIn & ~faultShutdownReq); // see R10

	// Fault pins pulled low on a logged breaker trip
	assign faultOut_n = 4'h0;
	assign faultOutEn = tripPerCh; // see R8

	// Attention sources, one per log register
	assign logAny[0] = |tripLog;
	assign logAny[1] = |uvFlags;
	assign logAny[2] = |ovFlags;
	assign logAny[3] = |ocFlags;

	// Attention pulled low while anything is logged
	assign alert_n = 1'b0;
	assign alertEn = |logAny; // see R9, R12
endmodule

// [hdl/fault_log_pkg.sv]
package fault_log_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_TRIP_LOG  = 8'h5f;
	localparam logic [7:0] ADDR_UV_FLAGS  = 8'h63;
	localparam logic [7:0] ADDR_OV_FLAGS  = 8'h64;
	localparam logic [7:0] ADDR_OC_FLAGS  = 8'h65;
	localparam logic [7:0] ADDR_FORCE_KEY = 8'h67;
	localparam logic [7:0] ADDR_FORCE_CTL = 8'h68;
	// Reset values and constants
	localparam logic [7:0] RST_FLAGS      = 8'h00;
	localparam logic [7:0] RST_KEY        = 8'h00;
	localparam logic [3:0] RST_FORCE      = 4'h0;
	localparam logic [7:0] UNLOCK_KEY     = 8'ha5;
	// Field positions: warning low nibble, critical/slow-trip high nibble
	localparam int         WARN_LSB       = 0;
	localparam int         CRIT_LSB       = 4;
	localparam int         NUM_CH         = 4;
endpackage

// [hdl/sticky_flag.sv]
`timescale 1ns/1ps
// One sticky bit; a set in the same cycle as a clear wins
module sticky_flag
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic setEv,
	input  wire logic clrEv,
	output logic      flag
);
	typedef struct packed {
		logic bit_ff;
	} state_t;
	state_t st_ff;
	state_t nxt_st;

	// Set dominates clear
	always_comb begin
		nxt_st = st_ff;
		if (clrEv) begin
			nxt_st.bit_ff = 1'b0;
		end
		if (setEv) begin
			nxt_st.bit_ff = 1'b1;
		end
	end

	// Register the state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign flag = st_ff.bit_ff;
endmodule

// [tb/fault_log_chk.sv]
`timescale 1ns/1ps
// Port checks of the fault log block
module fault_log_chk
	import fault_log_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       regWr,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic [3:0] slowTripEv,
	input wire logic [3:0] fastTripEv,
	input wire logic [3:0] channelRestart,
	input wire logic [3:0] faultShutdownReq,
	input wire logic [3:0] channelForceFlag,
	input wire logic [3:0] channelOn,
	input wire logic [3:0] faultOutEn,
	input wire logic       alertEn,
	input wire logic       alert_n
);
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_fh; regAddr==ADDR_FORCE_CTL |=> regRdata[7:4]==4'h0; endproperty
	a_fh: assert property (p_fh) else $error("force upper bits");
	property p_oh; regAddr==ADDR_OC_FLAGS |=> regRdata[7:4]==4'h0; endproperty
	a_oh: assert property (p_oh) else $error("oc upper bits");
	property p_lk;
		regWr && regAddr==ADDR_FORCE_KEY && regWdata!=UNLOCK_KEY |=> channelForceFlag==4'h0;
	endproperty
	a_lk: assert property (p_lk) else $error("force while locked");
	property p_fo; channelForceFlag[0] |-> channelOn[0]; endproperty
	a_fo: assert property (p_fo) else $error("forced channel off");
	property p_nm; !channelForceFlag[1] && faultShutdownReq[1] |-> !channelOn[1]; endproperty
	a_nm: assert property (p_nm) else $error("fault not shut");
	property p_sl; slowTripEv[0] |=> faultOutEn[0] && alertEn && !alert_n; endproperty
	a_sl: assert property (p_sl) else $error("trip not flagged");
	property p_cl;
		regWr && regAddr==ADDR_TRIP_LOG && regWdata==8'h00 && (slowTripEv|fastTripEv)==4'h0
		|=> faultOutEn==4'h0;
	endproperty
	a_cl: assert property (p_cl) else $error("trip not cleared");
	property p_hd; faultOutEn[0] && !regWr && !channelRestart[0] |=> faultOutEn[0]; endproperty
	a_hd: assert property (p_hd) else $error("trip lost");
	c_un: cover property (channelForceFlag!=4'h0);
	c_tr: cover property (faultOutEn!=4'h0);
	c_rs: cover property (channelRestart!=4'h0);
endmodule
bind fault_log_force_on_regs fault_log_chk i_fault_log_chk (.*);

// [tb/host_model.sv]
`timescale 1ns/1ps
// Host side of the register port
module host_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] regRdata,
	output logic            regWr,
	output logic      [7:0] regAddr,
	output logic      [7:0] regWdata
);
	initial begin
		regWr = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
	end
	// One-cycle strobe; stale data inverted
	task automatic wr(input logic [7:0] a, d);
		@(posedge ref_clk) #1;
		regWr = 1'b1;
		regAddr = a;
		regWdata = d;
		@(posedge ref_clk) #1;
		regWr = 1'b0;
		regWdata = ~d;
	endtask
	// Registered read, one cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge ref_clk) #1;
		regAddr = a;
		@(posedge ref_clk) #1;
		q = regRdata;
	endtask
endmodule

// [tb/tb_fault_log_force_on_regs.sv]
`timescale 1ns/1ps
module tb_fault_log_force_on_regs
	import fault_log_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic regWr, alert_n, alertEn;
	logic [7:0] regAddr, regWdata, regRdata, q;
	logic [3:0] lowVoltWarnEv, lowVoltCritEv, highVoltWarnEv, highVoltCritEv, overcurrentWarnEv;
	logic [3:0] slowTripEv, fastTripEv, channelRestart, channelEnableIn, faultShutdownReq;
	logic [3:0] channelForceFlag, channelOn, faultOut_n, faultOutEn;
	logic [27:0] evs = 28'h0;
	logic [11:0] ctl = 12'h0;
	int num_errors = 0;
	int num_checks = 0;
	assign {lowVoltWarnEv, lowVoltCritEv, highVoltWarnEv, highVoltCritEv} = evs[27:12];
	assign {overcurrentWarnEv, slowTripEv, fastTripEv} = evs[11:0];
	assign {channelRestart, channelEnableIn, faultShutdownReq} = ctl;
	always #20 ref_clk = ~ref_clk;
	host_model i_host_model (.*);
	fault_log_force_on_regs i_fault_log_force_on_regs (.*);
	task automatic cmp(input logic [7:0] g, e);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, e);
		i_host_model.rd(a, q);
		cmp(q, e);
	endtask
	task automatic give_verdict;
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial #100000 begin
		num_errors++;
		give_verdict;
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		#1 rst = 1'b0;
		rc(ADDR_TRIP_LOG, 8'h00);
		rc(ADDR_FORCE_KEY, 8'h00);
		i_host_model.wr(ADDR_FORCE_CTL, 8'hff);
		rc(ADDR_FORCE_CTL, 8'h0f);
		ctl = 12'h0f0;
		@(posedge ref_clk) #1 cmp({channelForceFlag, channelOn}, 8'h0f);
		ctl = 12'h0ff;
		i_host_model.wr(ADDR_FORCE_KEY, UNLOCK_KEY);
		cmp({channelForceFlag, channelOn}, 8'hff);
		i_host_model.wr(ADDR_FORCE_KEY, 8'h5a);
		cmp({channelForceFlag, channelOn}, 8'h00);
		// One-cycle burst of every event kind
		evs = 28'h1248312;
		@(posedge ref_clk) #1 evs = 28'h0;
		rc(ADDR_UV_FLAGS, 8'h21);
		rc(ADDR_OV_FLAGS, 8'h84);
		rc(ADDR_OC_FLAGS, 8'h03);
		cmp({2'h0, faultOutEn, alertEn, alert_n}, 8'h0e);
		cmp({faultOut_n, faultOutEn}, 8'h03);
		i_host_model.wr(ADDR_TRIP_LOG, 8'h01);
		rc(ADDR_TRIP_LOG, 8'h12);
		ctl = 12'h2ff;
		@(posedge ref_clk) #1 ctl = 12'h0ff;
		rc(ADDR_TRIP_LOG, 8'h10);
		i_host_model.wr(ADDR_TRIP_LOG, 8'h00);
		for (int a = 8'h63; a < 8'h66; a++) i_host_model.wr(a[7:0], 8'h5c);
		// Event and clear in one cycle: the set wins
		fork
			i_host_model.wr(ADDR_UV_FLAGS, 8'h00);
			begin
				@(posedge ref_clk) #1 evs = 28'h1000000;
				@(posedge ref_clk) #1 evs = 28'h0;
			end
		join
		rc(ADDR_UV_FLAGS, 8'h01);
		i_host_model.wr(ADDR_UV_FLAGS, 8'h00);
		rc(ADDR_OV_FLAGS, 8'h00);
		cmp({3'h0, faultOutEn, alertEn}, 8'h00);
		give_verdict;
	end
endmodule
